// [include/ioexp_pkg.sv]
// Constants and types shared by the eight-bit output expander
`default_nettype none
package ioexp_pkg;
    // ********************************************************
    // Bus addressing and command values
    // ********************************************************
    localparam logic [6:0] DEV_ADDR   = 7'h4A;   // Own 7-bit target address
    localparam logic [7:0] GC_ADDR    = 8'h00;   // General call with write bit
    localparam logic [7:0] SWRST_BYTE = 8'h06;   // Software reset command byte
    localparam logic [7:0] LATCH_RST  = 8'hFF;   // All port lines high
    localparam logic [3:0] CNT_BYTE   = 4'h8;    // Bits in one byte

    // ********************************************************
    // Timing
    // ********************************************************
    localparam int CLK_NS   = 100;               // Period of clk_sys
    localparam int SPIKE_NS = 50;                // Widest spike to reject
    // Longest time, rounded down, never below one cycle
    localparam int FILT_CYC = (SPIKE_NS / CLK_NS < 1) ? 1 : SPIKE_NS / CLK_NS;
    localparam logic [1:0] FILT_CNT = 2'(FILT_CYC);

    // ********************************************************
    // Types
    // ********************************************************
    typedef struct packed {
        logic scl;                               // Serial clock level
        logic sda;                               // Serial data level
    } ioexp_bus_s;

    typedef enum logic [3:0] {
        ST_IDLE  = 4'h0,                         // Waiting for a start
        ST_ADDR  = 4'h1,                         // Shifting the address byte
        ST_AACK  = 4'h2,                         // Acknowledging the address
        ST_WDATA = 4'h3,                         // Shifting a write byte
        ST_WACK  = 4'h4,                         // Acknowledging a write byte
        ST_RDATA = 4'h5,                         // Sending a read byte
        ST_RACK  = 4'h6,                         // Master acknowledge slot
        ST_RNEXT = 4'h7,                         // Master acked, reload next
        ST_GDATA = 4'h8,                         // Shifting a general call byte
        ST_GACK  = 4'h9,                         // Acknowledging reset command
        ST_GHOLD = 4'hA                          // Reset armed, waiting for stop
    } ioexp_state_e;
endpackage : ioexp_pkg
`default_nettype wire

// [rtl/ioexp_top.sv]
// Two-wire bus target driving eight latched push-pull port lines
// Summary of operation
// - Eight independent output-only port lines
// - Lines drive high after power-up
// - Latch bit one high, zero low
// - Write address with bit zero acknowledged
// - Each written data byte acknowledged
// - New value reaches lines after acknowledge
// - Unlimited write bytes, each replaces latch
// - Read address with bit one returns data
// - Read bytes return sampled pin levels
// - Unlimited read bytes, resampled each acknowledge
// - Power-on reset holds whole device
// - Reset release loads all defaults
// - Reject spikes under 50 ns
// - Respond to target address 4Ah
// - General call plus 06h is acknowledged
// - Other or extra general call bytes refused
// - Reset only on stop, restart cancels
`default_nettype none
module ioexp_top
    import ioexp_pkg::*;
(
    input  wire logic       clk_sys,     // System clock, 10 MHz
    input  wire logic       rst_n,       // Power-on reset, active low
    input  wire logic       scl_in,      // Serial clock pin level
    input  wire logic       sda_in,      // Serial data pin level
    output logic            sda_out,     // Serial data drive value
    output logic            sda_oe,      // Serial data pull-low enable
    output logic [7:0]      port_out,    // Port line drive levels
    input  wire logic [7:0] port_pin_in  // Port line levels at the pins
);
    // ********************************************************
    // Input synchronisers and spike filter
    // ********************************************************
    ioexp_bus_s  s1_r, s2_r;             // Two-stage synchroniser
    ioexp_bus_s  filt_r, filt_nxt;       // Filtered bus levels
    ioexp_bus_s  fp_r;                   // Filtered levels one cycle ago
    logic [1:0]  fc_scl_r, fc_scl_nxt;   // Clock spike counter
    logic [1:0]  fc_sda_r, fc_sda_nxt;   // Data spike counter
    logic [7:0]  p1_r, p2_r;             // Pin level synchroniser

    // Accept a new level only after it has stood longer than a spike
    function automatic logic [2:0] filt_step(input logic raw, input logic cur,
                                             input logic [1:0] cnt);
        if (raw == cur) begin
            filt_step = {cur, 2'h0};
        end else if (cnt == FILT_CNT) begin
            filt_step = {raw, 2'h0};
        end else begin
            filt_step = {cur, 2'(cnt + 2'h1)};
        end
    endfunction : filt_step

    // Next filtered levels
    always_comb begin
        {filt_nxt.scl, fc_scl_nxt} = filt_step(s2_r.scl, filt_r.scl, fc_scl_r);
        {filt_nxt.sda, fc_sda_nxt} = filt_step(s2_r.sda, filt_r.sda, fc_sda_r);
    end

    // Synchroniser and filter registers; idle bus reads high
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            s1_r     <= '1;
            s2_r     <= '1;
            filt_r   <= '1;
            fp_r     <= '1;
            fc_scl_r <= 2'h0;
            fc_sda_r <= 2'h0;
            p1_r     <= 8'h00;
            p2_r     <= 8'h00;
        end else begin
            s1_r     <= '{scl: scl_in, sda: sda_in};
            s2_r     <= s1_r;
            filt_r   <= filt_nxt;
            fp_r     <= filt_r;
            fc_scl_r <= fc_scl_nxt;
            fc_sda_r <= fc_sda_nxt;
            p1_r     <= port_pin_in;
            p2_r     <= p1_r;
        end
    end

    // ********************************************************
    // Bus conditions
    // ********************************************************
    logic scl_rise;                      // Clock rising edge
    logic scl_fall;                      // Clock falling edge
    logic bus_start;                     // Data falls, clock high
    logic bus_stop;                      // Data rises, clock high
    assign scl_rise  = filt_r.scl & ~fp_r.scl;
    assign scl_fall  = ~filt_r.scl & fp_r.scl;
    assign bus_start = filt_r.scl & fp_r.scl & fp_r.sda & ~filt_r.sda;
    assign bus_stop  = filt_r.scl & fp_r.scl & ~fp_r.sda & filt_r.sda;

    // ********************************************************
    // Protocol state machine and output latch
    // ********************************************************
    ioexp_state_e st_r, st_nxt;          // Protocol state
    logic [3:0]   cnt_r, cnt_nxt;        // Bit counter
    logic [7:0]   sh_r, sh_nxt;          // Shift register
    logic [7:0]   latch_r, latch_nxt;    // Output latch
    logic         oe_r, oe_nxt;          // Data pull-low request
    logic         swrst;                 // Software reset this cycle

    // Next protocol state; start and stop outrank every clock edge
    always_comb begin
        st_nxt    = st_r;
        cnt_nxt   = cnt_r;
        sh_nxt    = sh_r;
        latch_nxt = latch_r;
        oe_nxt    = oe_r;
        swrst     = 1'b0;
        if (bus_start) begin
            // Repeated start abandons an armed reset
            st_nxt  = ST_ADDR;
            cnt_nxt = 4'h0;
            oe_nxt  = 1'b0;
        end else if (bus_stop) begin
            st_nxt  = ST_IDLE;
            oe_nxt  = 1'b0;
            swrst   = (st_r == ST_GHOLD);
        end else begin
            unique case (st_r)
                ST_IDLE: begin
                    // Nothing addressed to us, keep data released
                    oe_nxt = 1'b0;
                end
                ST_GHOLD: begin
                    // A further byte gets no acknowledge and disarms the reset;
                    // a clock fall here can only come from such a byte
                    oe_nxt = 1'b0;
                    if (scl_fall) begin
                        st_nxt = ST_IDLE;
                    end
                end
                ST_ADDR, ST_WDATA, ST_GDATA: begin
                    if (scl_rise) begin
                        // First bit in ends up as bit seven
                        sh_nxt  = {sh_r[6:0], filt_r.sda};
                        cnt_nxt = 4'(cnt_r + 4'h1);
                    end else if (scl_fall && cnt_r == CNT_BYTE) begin
                        cnt_nxt = 4'h0;
                        st_nxt  = ST_IDLE;
                        if (st_r == ST_ADDR &&
                            (sh_r[7:1] == DEV_ADDR || sh_r == GC_ADDR)) begin
                            st_nxt = ST_AACK;
                            oe_nxt = 1'b1;
                        end else if (st_r == ST_WDATA) begin
                            st_nxt = ST_WACK;
                            oe_nxt = 1'b1;
                        end else if (st_r == ST_GDATA && sh_r == SWRST_BYTE) begin
                            st_nxt = ST_GACK;
                            oe_nxt = 1'b1;
                        end
                    end
                end
                ST_AACK: begin
                    if (scl_fall) begin
                        oe_nxt = 1'b0;
                        if (sh_r == GC_ADDR) begin
                            st_nxt = ST_GDATA;
                        end else if (sh_r[0]) begin
                            // Read returns the pins, not the latch
                            sh_nxt  = p2_r;
                            oe_nxt  = ~p2_r[7];
                            cnt_nxt = 4'h1;
                            st_nxt  = ST_RDATA;
                        end else begin
                            st_nxt = ST_WDATA;
                        end
                    end
                end
                ST_WACK: begin
                    // Lines change only once the acknowledge is over
                    if (scl_fall) begin
                        oe_nxt    = 1'b0;
                        latch_nxt = sh_r;
                        st_nxt    = ST_WDATA;
                    end
                end
                ST_RDATA: begin
                    if (scl_fall) begin
                        if (cnt_r == CNT_BYTE) begin
                            oe_nxt = 1'b0;
                            st_nxt = ST_RACK;
                        end else begin
                            sh_nxt  = {sh_r[6:0], 1'b0};
                            oe_nxt  = ~sh_r[6];
                            cnt_nxt = 4'(cnt_r + 4'h1);
                        end
                    end
                end
                ST_RACK: begin
                    // Master not acknowledging ends the read
                    if (scl_rise) begin
                        st_nxt = filt_r.sda ? ST_IDLE : ST_RNEXT;
                    end
                end
                ST_RNEXT: begin
                    // Fresh pin sample for every further byte
                    if (scl_fall) begin
                        sh_nxt  = p2_r;
                        oe_nxt  = ~p2_r[7];
                        cnt_nxt = 4'h1;
                        st_nxt  = ST_RDATA;
                    end
                end
                ST_GACK: begin
                    if (scl_fall) begin
                        oe_nxt = 1'b0;
                        st_nxt = ST_GHOLD;
                    end
                end
                default: begin
                    st_nxt = ST_IDLE;
                    oe_nxt = 1'b0;
                end
            endcase
        end
        if (swrst) begin
            latch_nxt = LATCH_RST;
        end
    end

    // Protocol registers; power-on reset loads every default
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            st_r     <= ST_IDLE;
            cnt_r    <= 4'h0;
            sh_r     <= 8'h00;
            latch_r  <= LATCH_RST;
            oe_r     <= 1'b0;
            sda_out  <= 1'b0;
            sda_oe   <= 1'b0;
            port_out <= LATCH_RST;
        end else begin
            st_r     <= st_nxt;
            cnt_r    <= cnt_nxt;
            sh_r     <= sh_nxt;
            latch_r  <= latch_nxt;
            oe_r     <= oe_nxt;
            // Open drain: only ever pulls low
            sda_out  <= 1'b0;
            sda_oe   <= oe_nxt;
            // Each line simply follows its latch bit
            port_out <= latch_nxt;
        end
    end

    // ********************************************************
    // Checks
    // ********************************************************
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    a_addr_ack: assert property (st_r == ST_ADDR && !bus_start && !bus_stop && scl_fall &&
        cnt_r == CNT_BYTE && sh_r[7:1] == DEV_ADDR |=> sda_oe && st_r == ST_AACK)
        else $error("own address not acknowledged");
    a_wr_apply: assert property ($changed(port_out) |->
        $past(st_r == ST_WACK && scl_fall) || $past(swrst))
        else $error("port lines changed outside acknowledge end");
    a_wr_byte_ack: assert property (st_r == ST_WDATA && !bus_start && !bus_stop &&
        scl_fall && cnt_r == CNT_BYTE |=> sda_oe ##0 st_r == ST_WACK)
        else $error("write byte not acknowledged");
    a_gc_refuse: assert property (st_r == ST_GDATA && !bus_start && !bus_stop && scl_fall &&
        cnt_r == CNT_BYTE && sh_r != SWRST_BYTE |=> !sda_oe && st_r == ST_IDLE)
        else $error("wrong general call byte acknowledged");
    a_gc_extra: assert property (st_r == ST_GHOLD |-> !sda_oe)
        else $error("extra general call byte acknowledged");
    a_gc_disarm: assert property (st_r == ST_GHOLD && !bus_start && !bus_stop && scl_fall
        |=> st_r == ST_IDLE)
        else $error("extra general call byte left reset armed");
    a_sw_reset: assert property (st_r == ST_GHOLD && bus_stop |=> port_out == LATCH_RST)
        else $error("software reset did not restore lines");
    a_rd_sample: assert property (st_r == ST_RNEXT && !bus_start && !bus_stop && scl_fall
        |=> sda_oe == ~$past(p2_r[7]) && sh_r == $past(p2_r))
        else $error("read byte not resampled from pins");
    a_spike_rej: assert property ($changed(filt_r.scl) |->
        $past(s2_r.scl) == filt_r.scl && $past(s2_r.scl, 2) == filt_r.scl)
        else $error("clock spike passed the filter");
endmodule : ioexp_top
`default_nettype wire

// [tb/ioexp_master.sv]
// Bus master model that drives the expander's clock and data wires
`default_nettype none
module ioexp_master
    import ioexp_pkg::*;
(
    input  wire logic clk_sys,  // System clock
    input  wire logic sda_bus,  // Resolved data wire
    output logic      scl_o,    // Clock drive, 1 releases
    output logic      sda_o     // Data drive, 1 releases
);
    timeunit 1ns;
    timeprecision 1ns;
    logic glitch = 1'b0;        // One-cycle clock spike in next slot
    initial begin
        scl_o = 1'b1;
        sda_o = 1'b1;
    end
    task automatic tk(input int n);
        repeat (n) @(posedge clk_sys);
    endtask : tk
    // ********************************************************
    // Bus conditions: st=1 start or restart, st=0 stop
    // ********************************************************
    task automatic cond(input logic st);
        tk(6);
        sda_o <= st;
        tk(2);
        scl_o <= 1'b1;
        tk(4);
        sda_o <= ~st;
        tk(4);
        if (st) scl_o <= 1'b0;
    endtask : cond
    // Nine 800 ns slots: six cycles low, two high, as the target answers late
    task automatic slot9(input logic [8:0] out9, output logic [8:0] in9);
        for (int i = 8; i >= 0; i--) begin
            tk(4);
            sda_o <= out9[i];
            scl_o <= glitch && i == 8;           // Spike must be dropped
            tk(1);
            scl_o <= 1'b0;
            tk(1);
            scl_o <= 1'b1;
            tk(2);
            in9[i] = sda_bus;                    // Sample late in high phase
            scl_o <= 1'b0;
        end
    endtask : slot9
endmodule : ioexp_master
`default_nettype wire

// [tb/ioexp_top_tb.sv]
// Self-checking bench for the eight-bit output expander
`default_nettype none
module ioexp_top_tb;
    import ioexp_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk_sys;                    // 10 MHz clock
    logic        rst_n;                      // Reset, active low
    logic        scl_o;                      // Master clock drive
    logic        sda_o;                      // Master data drive
    logic        sda_out;                    // Target data value
    logic        sda_oe;                     // Target pulls data
    logic [7:0]  port_out;                   // Port drive levels
    logic [7:0]  port_pin_in;                // Sensed pin levels
    logic [7:0]  flip = 8'h00;               // Pins differ from drive
    logic [31:0] seed = 32'h0000_470D;       // Xorshift state
    logic [8:0]  rx;                         // Last slot wire levels
    logic [7:0]  d;                          // Byte written
    logic [7:0]  old;                        // Expected earlier value
    int          error_cnt = 0;              // Mismatches
    int          n_compared = 0;             // Comparisons
    int          cyc = 0;                    // Cycles run
    // Pull-up wire: low whenever either party pulls
    wire logic   sda_bus = sda_o & ~(sda_oe & ~sda_out);

    initial clk_sys = 1'b0;
    always #50 clk_sys = ~clk_sys;
    // Pins follow drive, optionally disturbed from outside
    always @(posedge clk_sys) port_pin_in <= port_out ^ flip;
    // Hang guard
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            error_cnt++;
            finish_test();
        end
    end

    ioexp_top dut (
        .clk_sys     (clk_sys),
        .rst_n       (rst_n),
        .scl_in      (scl_o),
        .sda_in      (sda_bus),
        .sda_out     (sda_out),
        .sda_oe      (sda_oe),
        .port_out    (port_out),
        .port_pin_in (port_pin_in)
    );
    ioexp_master m (
        .clk_sys (clk_sys),
        .sda_bus (sda_bus),
        .scl_o   (scl_o),
        .sda_o   (sda_o)
    );

    // ********************************************************
    // Helpers
    // ********************************************************
    function automatic logic [7:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction : rnd
    function automatic logic [7:0] gc_cmd(input int i);
        return (i == 0) ? 8'h07 : SWRST_BYTE;    // First one is refused
    endfunction : gc_cmd
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        n_compared++;
        if (g !== e) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    // One byte out, then compare the target's acknowledge
    task automatic wr(input logic [7:0] b, input logic ack_exp);
        m.slot9({b, 1'b1}, rx);
        chk("ack", {7'h00, ack_exp}, {7'h00, ~rx[0]});
    endtask : wr
    task automatic finish_test();
        if (error_cnt == 0 && n_compared > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : finish_test

    // ********************************************************
    // Main sequence
    // ********************************************************
    initial begin
        rst_n <= 1'b0;
        repeat (6) @(posedge clk_sys);
        rst_n <= 1'b1;
        m.tk(2);
        chk("reset port", LATCH_RST, port_out);
        // Write burst, one byte crossed by a clock spike
        m.cond(1'b1);
        wr({DEV_ADDR, 1'b0}, 1'b1);
        for (int i = 0; i < 6; i++) begin
            d = (i == 0) ? 8'h00 : (i == 1) ? 8'hA5 : rnd();
            old = port_out;
            m.glitch = (i == 2);
            wr(d, 1'b1);
            chk("port early", old, port_out);
            m.tk(8);
            chk("port", d, port_out);
        end
        m.glitch = 1'b0;
        // Read burst via restart; pins disturbed so latch is not seen
        m.cond(1'b1);
        flip = rnd();
        wr({DEV_ADDR, 1'b1}, 1'b1);
        for (int i = 0; i < 4; i++) begin
            // Pins move at each acknowledge end; the target samples after it
            flip = rnd();
            old = port_out ^ flip;
            m.slot9({8'hFF, i == 3}, rx);
            chk("read", old, rx[8:1]);
        end
        m.cond(1'b0);
        flip = 8'h00;
        // Reset in mid-run with a written value on the lines
        rst_n <= 1'b0;
        m.tk(3);
        chk("reset hold", LATCH_RST, port_out);
        rst_n <= 1'b1;
        m.tk(2);
        chk("reset release", LATCH_RST, port_out);
        // Foreign address, general call read
        m.cond(1'b1);
        wr({DEV_ADDR ^ 7'h01, 1'b0}, 1'b0);
        m.cond(1'b0);
        m.cond(1'b1);
        wr({GC_ADDR[7:1], 1'b1}, 1'b0);
        m.cond(1'b0);
        // Software reset: bad byte, restart cancel, extra byte, proper stop
        for (int i = 0; i < 4; i++) begin
            m.cond(1'b1);
            wr({DEV_ADDR, 1'b0}, 1'b1);
            wr(8'h5A, 1'b1);
            m.cond(1'b1);
            wr(GC_ADDR, 1'b1);
            wr(gc_cmd(i), i != 0);
            if (i == 2) wr(rnd(), 1'b0);
            m.cond(i == 1);
            if (i == 1) m.cond(1'b0);
            m.tk(4);
            chk("swreset", (i == 3) ? LATCH_RST : 8'h5A, port_out);
        end
        finish_test();
    end
endmodule : ioexp_top_tb
`default_nettype wire
